// File: inc/tdf_pkg.sv
package tdf_pkg;
  localparam int TAPS_MAX = 36;
  localparam int TAP_IDX_W = 6;
  localparam int COEF_W = 18;
  localparam int COEF_FRAC = 16;
  localparam int SAMP_W = 24;
  localparam int WORD_W = 32;
  localparam int ACC_W = 48;
  localparam int DEC_W = 4;
  localparam int CNT_W = 32;
  localparam logic [DEC_W-1:0] DEC_MIN = 4'h1;
  localparam logic [TAP_IDX_W-1:0] TAPS_RST = 6'h01;
  localparam logic [DEC_W-1:0] DEC_RST = 4'h1;
  localparam logic [1:0] PACK_PHASES = 2'h3;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic signed [SAMP_W-1:0] SAT_POS = 24'h7FFFFF;
  localparam logic signed [SAMP_W-1:0] SAT_NEG = 24'h800000;

  typedef struct packed {
    logic [TAP_IDX_W-1:0] idx;
    logic signed [COEF_W-1:0] val;
  } tdf_coef_type;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic last;
  } tdf_word_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP = 3'b100
  } tdf_state_type;
endpackage : tdf_pkg

// File: rtl/tdf_skid.sv
`timescale 1ns/1ps
// Two-entry buffer: the input ready depends only on occupancy, so a receiver stall loses no word.
module tdf_skid (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire tdf_pkg::tdf_word_type in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output tdf_pkg::tdf_word_type out_data_o
);
  tdf_pkg::tdf_word_type mem_r [2];
  logic rd_ptr_r;
  logic wr_ptr_r;
  logic [1:0] cnt_r;
  wire push = in_valid_i && (cnt_r != 2'h2);
  wire pop = out_ready_i && (cnt_r != 2'h0);

  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = mem_r[rd_ptr_r];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (flush_i) begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_r[wr_ptr_r] <= in_data_i;
  end
endmodule : tdf_skid

// File: rtl/tdf_top.sv
`timescale 1ns/1ps
module tdf_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic START_I,
  input wire logic ABORT_I,
  input wire logic [tdf_pkg::CNT_W-1:0] SAMPLES_I,
  input wire logic CONTINUOUS_I,
  input wire logic PACK_EN_I,
  input wire logic [tdf_pkg::DEC_W-1:0] DECIM_I,
  input wire logic [tdf_pkg::TAP_IDX_W-1:0] TAPS_I,
  input wire logic COEF_WE_I,
  input wire tdf_pkg::tdf_coef_type COEF_I,
  input wire logic MOD_VALID_I,
  input wire logic MOD_BIT_I,
  input wire logic MEM_FULL_I,
  input wire logic OUT_READY_I,
  output logic OUT_VALID_O,
  output logic [tdf_pkg::WORD_W-1:0] OUT_DATA_O,
  output logic OUT_LAST_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic OVERFLOW_O,
  output logic SAT_O
);
  // Coefficients and bitstream history; the modulator bit maps to +1 or -1.
  logic signed [tdf_pkg::COEF_W-1:0] coef_r [tdf_pkg::TAPS_MAX];
  logic [tdf_pkg::TAPS_MAX-1:0] hist_r;
  tdf_pkg::tdf_state_type state_r;
  logic [tdf_pkg::TAP_IDX_W-1:0] taps_r;
  logic [tdf_pkg::DEC_W-1:0] dec_r;
  logic [tdf_pkg::DEC_W-1:0] dec_cnt_r;
  logic pack_r;
  logic cont_r;
  logic [tdf_pkg::CNT_W-1:0] left_r;
  logic [1:0] phase_r;
  logic [23:0] carry_r;
  logic filt_v_r;
  logic signed [tdf_pkg::SAMP_W-1:0] filt_r;
  logic sat_r;
  logic busy_r;
  logic done_r;
  logic ovf_r;

  function automatic logic signed [tdf_pkg::ACC_W-1:0] tap_term(input logic signed [tdf_pkg::COEF_W-1:0] c,
                                                                input logic b, input logic en);
    logic signed [tdf_pkg::ACC_W-1:0] e;
    e = tdf_pkg::ACC_W'(c);
    tap_term = !en ? '0 : (b ? e : -e);
  endfunction : tap_term

  // The full sum is one combinational tree; a pipelined tree would add latency but no behaviour.
  logic signed [tdf_pkg::ACC_W-1:0] term [tdf_pkg::TAPS_MAX];
  logic signed [tdf_pkg::ACC_W-1:0] acc;
  // The bit being sampled joins the sum in the same cycle, so tap 0 is always the newest bit.
  wire [tdf_pkg::TAPS_MAX-1:0] hist_nxt = {hist_r[tdf_pkg::TAPS_MAX-2:0], MOD_BIT_I};
  genvar g;
  generate
    for (g = 0; g < tdf_pkg::TAPS_MAX; g++) begin : gen_tap
      assign term[g] = tap_term(coef_r[g], hist_nxt[g], g < taps_r);
    end
  endgenerate
  always_comb begin
    acc = '0;
    for (int i = 0; i < tdf_pkg::TAPS_MAX; i++) acc = acc + term[i];
  end

  // Accumulator holds Q.16; the sample is Q1.23, so shift left by 7 and saturate.
  wire signed [tdf_pkg::ACC_W-1:0] scaled = acc <<< (tdf_pkg::SAMP_W - 1 - tdf_pkg::COEF_FRAC);
  wire too_hi = scaled > tdf_pkg::ACC_W'(tdf_pkg::SAT_POS);
  wire too_lo = scaled < tdf_pkg::ACC_W'(tdf_pkg::SAT_NEG);
  wire signed [tdf_pkg::SAMP_W-1:0] filt_nxt = too_hi ? tdf_pkg::SAT_POS :
                                               too_lo ? tdf_pkg::SAT_NEG : scaled[tdf_pkg::SAMP_W-1:0];

  wire running = (state_r == tdf_pkg::ST_RUN);
  wire keep = filt_v_r && (dec_cnt_r == dec_r);
  wire [tdf_pkg::TAP_IDX_W-1:0] taps_sel = (TAPS_I == '0) ? tdf_pkg::TAPS_RST :
                                           (TAPS_I > 6'(tdf_pkg::TAPS_MAX)) ? 6'(tdf_pkg::TAPS_MAX) : TAPS_I;
  wire [tdf_pkg::DEC_W-1:0] dec_sel = (DECIM_I == '0) ? tdf_pkg::DEC_MIN : DECIM_I;

  // Output word assembly.
  logic buf_in_ready;
  logic buf_out_valid;
  tdf_pkg::tdf_word_type buf_out;
  wire last_samp = !cont_r && (left_r == 32'h1);
  wire [23:0] s = filt_r;
  logic word_v;
  logic [31:0] word_d;
  always_comb begin
    word_v = 1'b0;
    word_d = '0;
    if (!pack_r) begin
      word_v = 1'b1;
      word_d = {tdf_pkg::FILL_BYTE, s};
    end else begin
      unique case (phase_r)
        2'h0: word_d = '0;
        2'h1: begin word_v = 1'b1; word_d = {s[7:0], carry_r}; end
        2'h2: begin word_v = 1'b1; word_d = {s[15:0], carry_r[15:0]}; end
        2'h3: begin word_v = 1'b1; word_d = {s, carry_r[7:0]}; end
      endcase
    end
  end
  wire emit = running && keep && word_v;
  wire stall = emit && !buf_in_ready;
  wire take = running && keep && !stall;

  tdf_skid u_skid (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .flush_i(START_I && !busy_r),
    .in_valid_i(emit),
    .in_ready_o(buf_in_ready),
    .in_data_i('{data: word_d, last: last_samp}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(OUT_READY_I || !OUT_VALID_O),
    .out_data_o(buf_out)
  );

  // A receiver stall at a kept sample, or full memory in any run cycle, means the data is lost: stop and flag it.
  wire overflow_evt = running && ((keep && stall) || MEM_FULL_I);

  always_ff @(posedge CLK_SYS_I) begin
    if (COEF_WE_I && !busy_r && COEF_I.idx < 6'(tdf_pkg::TAPS_MAX)) coef_r[COEF_I.idx] <= COEF_I.val;
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hist_r <= '0;
      filt_v_r <= 1'b0;
      filt_r <= '0;
      sat_r <= 1'b0;
    end else begin
      filt_v_r <= MOD_VALID_I;
      if (MOD_VALID_I) begin
        hist_r <= hist_nxt;
        filt_r <= filt_nxt;
      end
      // A saturation in the start cycle survives the clear.
      sat_r <= (sat_r && !(START_I && !busy_r)) || (MOD_VALID_I && (too_hi || too_lo));
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= tdf_pkg::ST_IDLE;
      taps_r <= tdf_pkg::TAPS_RST;
      dec_r <= tdf_pkg::DEC_RST;
      dec_cnt_r <= tdf_pkg::DEC_MIN;
      pack_r <= 1'b0;
      cont_r <= 1'b0;
      left_r <= '0;
      phase_r <= 2'h0;
      carry_r <= '0;
      done_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      unique case (state_r)
        tdf_pkg::ST_IDLE: if (START_I) begin
          state_r <= tdf_pkg::ST_RUN;
          taps_r <= taps_sel;
          dec_r <= dec_sel;
          dec_cnt_r <= tdf_pkg::DEC_MIN;
          pack_r <= PACK_EN_I;
          cont_r <= CONTINUOUS_I;
          left_r <= SAMPLES_I;
          phase_r <= 2'h0;
          done_r <= 1'b0;
          ovf_r <= 1'b0;
        end
        tdf_pkg::ST_RUN: begin
          if (filt_v_r && !stall) dec_cnt_r <= (dec_cnt_r == dec_r) ? tdf_pkg::DEC_MIN : dec_cnt_r + 4'h1;
          if (take) begin
            unique case (phase_r)
              2'h0: carry_r <= s;
              2'h1: carry_r <= {8'h00, s[23:8]};
              2'h2: carry_r <= {16'h0000, s[23:16]};
              2'h3: carry_r <= '0;
            endcase
            if (pack_r) phase_r <= (phase_r == tdf_pkg::PACK_PHASES) ? 2'h0 : phase_r + 2'h1;
            if (!cont_r) left_r <= left_r - 32'h1;
          end
          if (overflow_evt) begin
            ovf_r <= 1'b1;
            state_r <= tdf_pkg::ST_STOP;
          end else if (ABORT_I || (take && last_samp)) begin
            done_r <= 1'b1;
            state_r <= tdf_pkg::ST_STOP;
          end
        end
        tdf_pkg::ST_STOP: if (!buf_out_valid && !OUT_VALID_O) state_r <= tdf_pkg::ST_IDLE;
        default: state_r <= tdf_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      OUT_VALID_O <= 1'b0;
      OUT_DATA_O <= '0;
      OUT_LAST_O <= 1'b0;
      BUSY_O <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      if (OUT_READY_I || !OUT_VALID_O) OUT_VALID_O <= buf_out_valid;
      // Data loads only with a real word, so the unreset buffer memory never reaches the pins.
      if ((OUT_READY_I || !OUT_VALID_O) && buf_out_valid) begin
        OUT_DATA_O <= buf_out.data;
        OUT_LAST_O <= buf_out.last;
      end
      busy_r <= (state_r != tdf_pkg::ST_IDLE) || START_I;
      BUSY_O <= (state_r != tdf_pkg::ST_IDLE);
    end
  end

  assign DONE_O = done_r;
  assign OVERFLOW_O = ovf_r;
  assign SAT_O = sat_r;
endmodule : tdf_top

// File: dv/tdf_host.sv
`timescale 1ns/1ps
// Host sink; slow mode drops ready every other cycle so the two-entry buffer must hold words.
module tdf_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic full_i,
  input wire logic valid_i,
  input wire logic [tdf_pkg::WORD_W-1:0] data_i,
  input wire logic last_i,
  output logic ready_o,
  output logic mem_full_o
);
  logic [32:0] q[$];
  logic tog_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) tog_r <= 1'b0;
    else tog_r <= ~tog_r;
  end
  assign ready_o = ~slow_i | tog_r;
  assign mem_full_o = full_i;
  always @(posedge clk_i) begin
    if (valid_i && ready_o) q.push_back({last_i, data_i});
  end
endmodule : tdf_host

// File: dv/tdf_top_chk.sv
`timescale 1ns/1ps
module tdf_top_chk (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic START_I,
  input wire logic PACK_EN_I,
  input wire logic MEM_FULL_I,
  input wire logic OUT_READY_I,
  input wire logic OUT_VALID_O,
  input wire logic [tdf_pkg::WORD_W-1:0] OUT_DATA_O,
  input wire logic BUSY_O,
  input wire logic OVERFLOW_O,
  input wire logic SAT_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_hold; OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O; endproperty
  a_hold: assert property (p_hold) else $error("word dropped under stall");
  property p_data; OUT_VALID_O && !OUT_READY_I |=> $stable(OUT_DATA_O); endproperty
  a_data: assert property (p_data) else $error("word changed under stall");
  property p_fill; BUSY_O && OUT_VALID_O && !PACK_EN_I |-> OUT_DATA_O[31:24] == 8'h00; endproperty
  a_fill: assert property (p_fill) else $error("filler byte not zero");
  property p_ovf; BUSY_O && MEM_FULL_I |-> ##[1:3] OVERFLOW_O; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
  property p_ovf_keep; OVERFLOW_O && !START_I |=> OVERFLOW_O; endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");
  property p_stop; $rose(OVERFLOW_O) |-> ##[0:30] !BUSY_O; endproperty
  a_stop: assert property (p_stop) else $error("run not stopped on overflow");
  property p_sat_keep; SAT_O && !START_I |=> SAT_O; endproperty
  a_sat_keep: assert property (p_sat_keep) else $error("saturation flag lost");
  property p_src; $rose(OUT_VALID_O) |-> BUSY_O; endproperty
  a_src: assert property (p_src) else $error("word outside a run");
endmodule : tdf_top_chk
bind tdf_top tdf_top_chk chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .START_I(START_I), .PACK_EN_I(PACK_EN_I),
  .MEM_FULL_I(MEM_FULL_I), .OUT_READY_I(OUT_READY_I), .OUT_VALID_O(OUT_VALID_O), .OUT_DATA_O(OUT_DATA_O),
  .BUSY_O(BUSY_O), .OVERFLOW_O(OVERFLOW_O), .SAT_O(SAT_O));

// File: dv/test_tdf_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", n, e, s); end end
module test_tdf_top;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, cont = 1'b0, pack = 1'b0, we = 1'b0;
  logic mvalid = 1'b0, mbit = 1'b0, slow = 1'b0, full = 1'b0, abort = 1'b0;
  logic [31:0] samples = 32'h0;
  logic [3:0] dec = 4'h1;
  logic [5:0] taps = 6'h01;
  tdf_pkg::tdf_coef_type coef = '0;
  logic ready, mfull, ovalid, olast, busy, done, ovf, sat;
  logic [31:0] odata;
  int failures = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  tdf_top dut (.CLK_SYS_I(clk), .RST_I(rst), .START_I(start), .ABORT_I(abort), .SAMPLES_I(samples),
    .CONTINUOUS_I(cont), .PACK_EN_I(pack), .DECIM_I(dec), .TAPS_I(taps), .COEF_WE_I(we), .COEF_I(coef),
    .MOD_VALID_I(mvalid), .MOD_BIT_I(mbit), .MEM_FULL_I(mfull), .OUT_READY_I(ready), .OUT_VALID_O(ovalid),
    .OUT_DATA_O(odata), .OUT_LAST_O(olast), .BUSY_O(busy), .DONE_O(done), .OVERFLOW_O(ovf), .SAT_O(sat));
  tdf_host host (.clk_i(clk), .rst_i(rst), .slow_i(slow), .full_i(full), .valid_i(ovalid), .data_i(odata),
    .last_i(olast), .ready_o(ready), .mem_full_o(mfull));
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task load(input logic [5:0] i, input logic [17:0] v);
    @(posedge clk);
    we <= 1'b1;
    coef <= {i, v};
    @(posedge clk);
    we <= 1'b0;
  endtask : load
  // Bit k of the stream is m[k % per]; fl raises memory full part way through, else a continuous run is aborted there.
  task run(input logic [3:0] n, input logic [5:0] t, input logic p, c, input logic [31:0] s,
    input logic [15:0] m, input int per, input logic fl);
    int k;
    host.q.delete();
    @(posedge clk);
    dec <= n;
    taps <= t;
    pack <= p;
    cont <= c;
    samples <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 600 && (k < 2 || busy === 1'b1); k++) begin
      mvalid <= 1'b1;
      mbit <= m[k % per];
      full <= fl && k > 20;
      abort <= c && !fl && k > 20;
      @(posedge clk);
    end
    mvalid <= 1'b0;
    full <= 1'b0;
    abort <= 1'b0;
    if (k >= 600) begin
      failures++;
      conclude();
    end
  endtask : run
  task t_decim;
    for (int n = 1; n <= 15; n++) begin
      slow <= n[0];
      run(n[3:0], 6'h01, 1'b0, 1'b0, 32'h2, 16'h1 << (n - 1), n, 1'b0);
      `CHK("count", 2, host.q.size())
      `CHK("first", 33'h000400000, host.q[0])
      `CHK("second", 33'h100400000, host.q[1])
      `CHK("done", 1'b1, done)
    end
    slow <= 1'b0;
  endtask : t_decim
  task t_pack;
    run(4'h1, 6'h01, 1'b1, 1'b0, 32'h4, 16'h0009, 4, 1'b0);
    `CHK("pcount", 3, host.q.size())
    `CHK("w0", 33'h000400000, host.q[0])
    `CHK("w1", 33'h00000C000, host.q[1])
    `CHK("w2", 33'h1400000C0, host.q[2])
  endtask : t_pack
  task t_sat;
    load(6'h00, 18'h10000);
    load(6'h01, 18'h10000);
    run(4'h2, 6'h02, 1'b0, 1'b0, 32'h1, 16'hFFFF, 1, 1'b0);
    `CHK("satword", 33'h1007FFFFF, host.q[0])
    `CHK("sat", 1'b1, sat)
  endtask : t_sat
  task t_abort;
    run(4'h3, 6'h01, 1'b1, 1'b1, 32'h0, 16'h0001, 1, 1'b0);
    `CHK("abw0", 33'h0FF7FFFFF, host.q[0])
    `CHK("abw1", 33'h0FFFF7FFF, host.q[1])
    `CHK("abdone", 1'b1, done)
    `CHK("abovf", 1'b0, ovf)
    `CHK("absat", 1'b1, sat)
  endtask : t_abort
  task t_ovf;
    run(4'h1, 6'h01, 1'b0, 1'b1, 32'h0, 16'h0001, 1, 1'b1);
    `CHK("ovf", 1'b1, ovf)
    `CHK("ovfdone", 1'b0, done)
  endtask : t_ovf
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    load(6'h00, 18'h08000);
    t_decim();
    t_pack();
    t_sat();
    t_abort();
    t_ovf();
    conclude();
  end
endmodule : test_tdf_top
